/* hw/pskey_pkg.sv */
/*
 Package for the profile pin shift keying select block: register offsets,
 field positions, reset values and enumerations.
 Assumes nothing of its surroundings beyond a SystemVerilog elaborator.
*/
package pskey_pkg;

	// ============================================================
	// APB register offsets (byte addresses)
	localparam logic [7:0] PSKEY_OFF_CTRL   = 8'h00;
	localparam logic [7:0] PSKEY_OFF_STATUS = 8'h04;
	localparam logic [7:0] PSKEY_OFF_WORD   = 8'h08;
	localparam logic [7:0] PSKEY_OFF_PROF0  = 8'h40;
	localparam logic [7:0] PSKEY_OFF_PROF1  = 8'h80;

	// ============================================================
	// Profile map: dedicated words and keying profiles
	localparam logic [7:0] PSKEY_REG_FREQ0  = 8'h04;
	localparam logic [7:0] PSKEY_REG_PHASE0 = 8'h05;
	localparam logic [7:0] PSKEY_REG_AMPL0  = 8'h06;
	localparam logic [7:0] PSKEY_REG_PBASE  = 8'h09;
	localparam logic [7:0] PSKEY_REG_PFIRST = 8'h0A;
	localparam logic [7:0] PSKEY_REG_PLAST  = 8'h18;

	// ============================================================
	// Control register field positions
	localparam int PSKEY_F_LEVEL = 0;
	localparam int PSKEY_F_RAMP  = 2;
	localparam int PSKEY_F_PPC   = 4;
	localparam int PSKEY_F_KPS   = 7;
	localparam int PSKEY_F_SWEEP = 9;
	localparam logic [31:0] PSKEY_CTRL_RST = 32'h0000_0000;

	// Word widths for phase and amplitude keying
	localparam int PSKEY_PHASE_W = 14;
	localparam int PSKEY_AMPL_W  = 10;

	// ============================================================
	// Enumerations
	typedef enum logic [1:0] {
		PSKEY_LVL2,
		PSKEY_LVL4,
		PSKEY_LVL8,
		PSKEY_LVL16
	} pskey_level_t;

	typedef enum logic [1:0] {
		PSKEY_RAMP_OFF,
		PSKEY_RAMP_PIN23,
		PSKEY_RAMP_PIN3,
		PSKEY_RAMP_SERIAL
	} pskey_ramp_t;

	typedef enum logic [1:0] {
		PSKEY_KEY_OFF,
		PSKEY_KEY_AMPL,
		PSKEY_KEY_FREQ,
		PSKEY_KEY_PHASE
	} pskey_kps_t;

	typedef enum logic [1:0] {
		PSKEY_RR_NONE,
		PSKEY_RR_UP,
		PSKEY_RR_DOWN
	} pskey_rreq_t;

endpackage

/* hw/pskey_sel_if.sv */
/*
 Interface carrying the decode request and answer between the top module
 and the profile decoder.
 Assumes both ends run on the same clock.
*/
`timescale 1ns/1ps
interface pskey_sel_if;
	import pskey_pkg::*;

	logic [1:0] level;
	logic [1:0] ramp;
	logic [2:0] profile_pin_config;
	logic [3:0] pins;
	logic [2:0] sdio;
	logic [3:0] index;
	logic       valid;
	logic [1:0] rreq;
	logic       serial_only;

	modport ctl (output level, ramp, profile_pin_config, pins, sdio,
		input index, valid, rreq, serial_only);
	modport dec (input level, ramp, profile_pin_config, pins, sdio,
		output index, valid, rreq, serial_only);
endinterface

/* hw/pskey_decode.sv */
/*
 Combinational profile pin decoder: forms the profile index and the
 amplitude ramp request from the synchronised pins and the mode fields.
 Assumes pins are already synchronised to the block clock.
*/
`timescale 1ns/1ps
module pskey_decode
(
	pskey_sel_if.dec s
);
	import pskey_pkg::*;

	// ============================================================
	// Pin decode, the lower-numbered profile pin is the more significant index bit
	always_comb
	begin
		s.index       = 4'h0;
		s.valid       = 1'b1;
		s.rreq        = PSKEY_RR_NONE;
		s.serial_only = 1'b0;
		case (s.ramp)
		PSKEY_RAMP_OFF:
		begin
			if (s.level == PSKEY_LVL2)
				s.index = {3'h0, s.pins[1]};
			else if (s.level == PSKEY_LVL4 && s.profile_pin_config == 3'h3)
				s.index = {2'h0, s.pins[0], s.pins[1]};
			else if (s.level == PSKEY_LVL8 && s.profile_pin_config[1:0] == 2'h1)
				s.index = {1'h0, s.pins[0], s.pins[1], s.pins[2]};
			else if (s.level == PSKEY_LVL16 && s.profile_pin_config[1:0] == 2'h1)
				s.index = {s.pins[0], s.pins[1], s.pins[2], s.pins[3]};
			else
				s.valid = 1'b0;
		end
		PSKEY_RAMP_PIN23:
		begin
			// Only 2-level exists here; low pin means ramp up
			if (s.level != PSKEY_LVL2)
				s.valid = 1'b0;
			else if (s.profile_pin_config == 3'h0)
			begin
				s.index = {3'h0, s.pins[1]};
				s.rreq  = s.pins[3] ? PSKEY_RR_DOWN : PSKEY_RR_UP;
			end
			else if (s.profile_pin_config == 3'h3)
			begin
				s.index = {3'h0, s.pins[0]};
				s.rreq  = s.pins[2] ? PSKEY_RR_DOWN : PSKEY_RR_UP;
			end
			else
				s.valid = 1'b0;
		end
		PSKEY_RAMP_PIN3:
		begin
			if (s.level == PSKEY_LVL8 && s.profile_pin_config[1:0] == 2'h1)
			begin
				s.index = {1'h0, s.pins[0], s.pins[1], s.pins[2]};
				s.rreq  = s.pins[3] ? PSKEY_RR_DOWN : PSKEY_RR_UP;
			end
			else
				s.valid = 1'b0;
		end
		default:
		begin
			s.serial_only = 1'b1;
			if (s.level == PSKEY_LVL2)
			begin
				s.index = {3'h0, s.pins[1]};
				if (s.sdio == 3'b010)
					s.rreq = PSKEY_RR_UP;
				// Bit zero is serial pin one, so pins 0,1,1 read 110
				else if (s.sdio == 3'b110)
					s.rreq = PSKEY_RR_DOWN;
			end
			else if (s.level == PSKEY_LVL4 && s.profile_pin_config == 3'h0)
			begin
				s.index = {2'h0, s.pins[2], s.pins[3]};
				s.rreq  = s.sdio[1] ? PSKEY_RR_DOWN : PSKEY_RR_UP;
			end
			else if (s.level == PSKEY_LVL4 && s.profile_pin_config == 3'h3)
			begin
				s.index = {2'h0, s.pins[0], s.pins[1]};
				s.rreq  = s.sdio[0] ? PSKEY_RR_DOWN : PSKEY_RR_UP;
			end
			else if (s.level == PSKEY_LVL16 && s.profile_pin_config[1:0] == 2'h1)
			begin
				s.index = {s.pins[0], s.pins[1], s.pins[2], s.pins[3]};
				s.rreq  = s.sdio[0] ? PSKEY_RR_DOWN : PSKEY_RR_UP;
			end
			else
				s.valid = 1'b0;
		end
		endcase
	end
endmodule

/* hw/pskey_top.sv */
/*
 Profile pin shift keying select: APB registers, pin synchronisers,
 profile store and output word for the primary channel.
 Assumes an APB master on clock and asynchronous profile and serial pins.
*/
`timescale 1ns/1ps
module pskey_top
(
	input  wire logic                     clock,
	input  wire logic                     nrst,
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [7:0]               paddr,
	input  wire logic [31:0]              pwdata,
	output logic      [31:0]              prdata,
	output logic                          pready,
	output logic                          pslverr,
	input  wire logic [3:0]               profile_pin,
	input  wire logic [2:0]               serial_data_pin,
	output logic      [31:0]              primary_channel_word,
	output pskey_pkg::pskey_kps_t         keying_parameter_select,
	output logic      [7:0]               profile_address,
	output logic                          ramp_up,
	output logic                          ramp_down,
	output logic                          serial_single_bit
);
	import pskey_pkg::*;

	// ============================================================
	// Reset release
	logic [1:0] rst_sync;
	logic       rst_n;

	always_ff @(posedge clock or negedge nrst)
	begin
		if (!nrst)
			rst_sync <= 2'b00;
		else
			rst_sync <= {rst_sync[0], 1'b1};
	end
	assign rst_n = rst_sync[1];

	// ============================================================
	// Pin synchronisers, stage one read only by stage two
	logic [6:0] pin_meta;
	logic [6:0] pin_sync;

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			pin_meta <= 7'h00;
			pin_sync <= 7'h00;
		end
		else
		begin
			pin_meta <= {serial_data_pin, profile_pin};
			pin_sync <= pin_meta;
		end
	end

	// ============================================================
	// Registers: control, profile zero words and profiles 1..15
	logic [31:0] ctrl;
	logic [31:0] word0 [3];
	logic [31:0] prof [1:15];
	logic [31:0] next_ctrl;
	logic [31:0] next_word0 [3];
	logic [31:0] next_prof [1:15];
	logic [31:0] next_prdata;
	logic        next_pslverr;
	logic        wr_en;
	logic        rd_en;

	assign wr_en  = psel && penable && pwrite;
	assign rd_en  = psel && !penable && !pwrite;
	assign pready = 1'b1;

	// ============================================================
	// Decoder hookup
	pskey_sel_if sel ();
	pskey_decode pskey_decode_i (.s(sel));

	assign sel.level = ctrl[PSKEY_F_LEVEL +: 2];
	assign sel.ramp  = ctrl[PSKEY_F_RAMP +: 2];
	assign sel.profile_pin_config   = ctrl[PSKEY_F_PPC +: 3];
	assign sel.pins  = pin_sync[3:0];
	assign sel.sdio  = pin_sync[6:4];

	// Address decode and write data; read data is launched in setup
	always_comb
	begin
		next_ctrl    = ctrl;
		next_word0   = word0;
		next_prof    = prof;
		next_prdata  = prdata;
		next_pslverr = 1'b0;
		if (rd_en)
			next_prdata = 32'h0000_0000;
		if (paddr == PSKEY_OFF_CTRL)
		begin
			if (wr_en)
				next_ctrl = pwdata & 32'h0000_03FF;
			else if (rd_en)
				next_prdata = ctrl;
		end
		else if (paddr == PSKEY_OFF_STATUS)
		begin
			if (rd_en)
				next_prdata = {16'h0, sel.serial_only, sel.valid,
					sel.rreq, sel.index, 1'b0, pin_sync};
		end
		else if (paddr == PSKEY_OFF_WORD)
		begin
			if (rd_en)
				next_prdata = primary_channel_word;
		end
		else if (paddr >= PSKEY_OFF_PROF0 && paddr < PSKEY_OFF_PROF0 + 8'h0C)
		begin
			// Dedicated frequency, phase, amplitude words
			if (wr_en)
				next_word0[paddr[3:2]] = pwdata;
			else if (rd_en)
				next_prdata = word0[paddr[3:2]];
		end
		else if (paddr >= PSKEY_OFF_PROF1 + 8'h04 && paddr <= 8'hBC)
		begin
			if (wr_en)
				next_prof[paddr[5:2]] = pwdata;
			else if (rd_en)
				next_prdata = prof[paddr[5:2]];
		end
		else if (psel && !penable)
			next_pslverr = 1'b1; // Set in setup so it stands in access
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ctrl    <= PSKEY_CTRL_RST;
			word0   <= '{default: 32'h0000_0000};
			prof    <= '{default: 32'h0000_0000};
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else
		begin
			ctrl    <= next_ctrl;
			word0   <= next_word0;
			prof    <= next_prof;
			prdata  <= next_prdata;
			pslverr <= next_pslverr;
		end
	end

	// ============================================================
	// Output word selection, registered one cycle after decode
	pskey_kps_t  kps;
	logic [31:0] raw;
	logic [31:0] next_word;
	logic [7:0]  next_addr;
	logic        next_up;
	logic        next_down;

	assign kps = pskey_kps_t'(ctrl[PSKEY_F_KPS +: 2]);

	always_comb
	begin
		next_word = 32'h0000_0000;
		next_addr = 8'h00;
		raw       = 32'h0000_0000;
		// Sweep set or keying off holds the output at zero
		if (kps != PSKEY_KEY_OFF && !ctrl[PSKEY_F_SWEEP]
			&& sel.valid)
		begin
			if (sel.index == 4'h0)
			begin
				raw = word0[{1'b0, kps == PSKEY_KEY_PHASE}
					+ {1'b0, kps == PSKEY_KEY_AMPL} * 2'd2
					- 2'd0];
				next_addr = (kps == PSKEY_KEY_FREQ) ? PSKEY_REG_FREQ0 :
					(kps == PSKEY_KEY_PHASE) ? PSKEY_REG_PHASE0 :
					PSKEY_REG_AMPL0;
			end
			else
			begin
				raw       = prof[sel.index];
				next_addr = PSKEY_REG_PBASE + {4'h0, sel.index};
			end
			// MSB-aligned narrow words, excess bits dropped
			if (kps == PSKEY_KEY_PHASE)
				next_word = {18'h0, raw[31 -: PSKEY_PHASE_W]};
			else if (kps == PSKEY_KEY_AMPL)
				next_word = {22'h0, raw[31 -: PSKEY_AMPL_W]};
			else
				next_word = raw;
		end
		next_up   = sel.rreq == PSKEY_RR_UP;
		next_down = sel.rreq == PSKEY_RR_DOWN;
	end

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			primary_channel_word <= 32'h0000_0000;
			profile_address      <= 8'h00;
			ramp_up              <= 1'b0;
			ramp_down            <= 1'b0;
			serial_single_bit    <= 1'b0;
		end
		else
		begin
			primary_channel_word <= next_word;
			profile_address      <= next_addr;
			ramp_up              <= next_up;
			ramp_down            <= next_down;
			serial_single_bit    <= sel.serial_only;
		end
	end

	assign keying_parameter_select = kps;
endmodule

/* dv/pskey_props.sv */
/*
 Checker for the keying select top: pin decode, ramp requests, refusals.
 Assumes it is bound to pskey_top and sees only its ports.
*/
`timescale 1ns/1ps
module pskey_props
	import pskey_pkg::*;
(
	input wire logic                  clock,
	input wire logic                  nrst,
	input wire logic                  psel,
	input wire logic                  penable,
	input wire logic                  pwrite,
	input wire logic [7:0]            paddr,
	input wire logic [31:0]           pwdata,
	input wire logic [31:0]           prdata,
	input wire logic                  pready,
	input wire logic                  pslverr,
	input wire logic [3:0]            profile_pin,
	input wire logic [2:0]            serial_data_pin,
	input wire logic [31:0]           primary_channel_word,
	input wire pskey_pkg::pskey_kps_t keying_parameter_select,
	input wire logic [7:0]            profile_address,
	input wire logic                  ramp_up,
	input wire logic                  ramp_down,
	input wire logic                  serial_single_bit
);
	// ============================================================
	// Shadow of the control word, taken when the slave takes it
	logic [9:0] ctl;
	logic       quiet;
	logic [3:0] idx;
	logic [7:0] a0;
	logic       bad;
	always_ff @(posedge clock or negedge nrst)
		if (!nrst)
			ctl <= '0;
		else if (psel && penable && pwrite && paddr == 8'h00)
			ctl <= pwdata[9:0];
	// Derived views; quiet keeps profile writes out of hold windows
	assign quiet = !(psel && pwrite);
	assign idx = {profile_pin[0], profile_pin[1], profile_pin[2],
		profile_pin[3]};
	assign a0 = (ctl[8:7] == 2'd1) ? 8'h06 :
		(ctl[8:7] == 2'd2) ? 8'h04 : 8'h05;
	assign bad = (ctl[3:2] == 2'd1 && ctl[1:0] != 2'd0) ||
		(ctl[3:2] == 2'd2 && ctl[1:0] != 2'd2) ||
		(ctl[3:2] == 2'd3 && ctl[1:0] == 2'd2);

	default clocking @(posedge clock); endclocking
	default disable iff (!nrst);
	// Five quiet cycles cover the two synchroniser flops and output
	sequence s_calm;
		($stable(profile_pin) && $stable(serial_data_pin) &&
			$stable(ctl) && quiet)[*5];
	endsequence

	property p_two;
		s_calm ##0 (ctl[3:0] == 4'h0 && ctl[8:7] != 2'd0) |->
			profile_address == (profile_pin[1] ? 8'h0A : a0);
	endproperty
	a_two: assert property (p_two) else $error("two-level pick");
	property p_sixteen;
		s_calm ##0 (ctl[5:0] == 6'h13 && ctl[8:7] != 2'd0 &&
			!ctl[9] && idx != 4'h0) |->
			profile_address == 8'h09 + 8'(idx);
	endproperty
	a_sixteen: assert property (p_sixteen) else $error("index order");
	property p_pinramp;
		s_calm ##0 (ctl[6:0] == 7'h04) |->
			ramp_down == profile_pin[3] && ramp_up != profile_pin[3];
	endproperty
	a_pinramp: assert property (p_pinramp) else $error("pin ramp");
	property p_pin3;
		s_calm ##0 (ctl[5:0] == 6'h1A) |->
			ramp_down == profile_pin[3] && ramp_up != profile_pin[3];
	endproperty
	a_pin3: assert property (p_pin3) else $error("pin three ramp");
	property p_sdio;
		s_calm ##0 (ctl[3:0] == 4'hC && serial_data_pin[1:0] == 2'b10)
			|-> ramp_down == serial_data_pin[2] &&
			ramp_up != serial_data_pin[2];
	endproperty
	a_sdio: assert property (p_sdio) else $error("serial ramp");
	property p_refuse;
		s_calm ##0 bad |->
			primary_channel_word == '0 && !ramp_up && !ramp_down;
	endproperty
	a_refuse: assert property (p_refuse) else $error("bad mode");
	property p_serial;
		s_calm |-> serial_single_bit == (ctl[3:2] == 2'd3);
	endproperty
	a_serial: assert property (p_serial) else $error("single bit");
	property p_kps;
		s_calm |-> keying_parameter_select == ctl[8:7];
	endproperty
	a_kps: assert property (p_kps) else $error("keying type");
	property p_excl;
		!(ramp_up && ramp_down);
	endproperty
	a_excl: assert property (p_excl) else $error("both ramps");
	property p_hold;
		s_calm ##1 quiet |->
			$stable(primary_channel_word) && $stable(profile_address);
	endproperty
	a_hold: assert property (p_hold) else $error("word moved");
	property p_range;
		profile_address inside {8'h00, [8'h04:8'h06], [8'h0A:8'h18]};
	endproperty
	a_range: assert property (p_range) else $error("address");
	c_sup: cover property (serial_single_bit && ramp_up);
	c_down: cover property (ramp_down);
	c_err: cover property (pslverr);
endmodule

bind pskey_top pskey_props pskey_props_i (.clock(clock), .nrst(nrst),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .profile_pin(profile_pin),
	.serial_data_pin(serial_data_pin),
	.primary_channel_word(primary_channel_word),
	.keying_parameter_select(keying_parameter_select),
	.profile_address(profile_address), .ramp_up(ramp_up),
	.ramp_down(ramp_down), .serial_single_bit(serial_single_bit));

/* dv/pskey_ctrl_model.sv */
/*
 Controller model: drives profile and serial data pins as static levels.
 Assumes the bench asks for new levels just after a rising edge.
*/
`timescale 1ns/1ps
module pskey_ctrl_model
(
	input  wire logic       clock,
	input  wire logic [3:0] want_pins,
	input  wire logic [2:0] want_sdio,
	output logic      [3:0] profile_pin,
	output logic      [2:0] serial_data_pin
);
	// ============================================================
	// Pins move one edge after a request; all requested bits change together on that edge
	initial
	begin
		profile_pin = '0;
		serial_data_pin = '0;
	end
	always @(posedge clock)
	begin
		profile_pin <= want_pins;
		serial_data_pin <= want_sdio;
	end
endmodule

/* dv/profile_pin_shift_keying_select_bench.sv */
/*
 Bench for the keying select top: APB setup, then a table of modes.
 Assumes the package constants and a 250 MHz clock.
*/
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin \
	mismatches++; $display("ERROR %0t got %h want %h", $time, a, b); \
	end end
module profile_pin_shift_keying_select_bench;
	import pskey_pkg::*;
	logic        clock = 0, nrst = 0, psel = 0, penable = 0, pwrite = 0;
	logic        pready, pslverr, ramp_up, ramp_down, serial_single_bit;
	logic        err;
	logic [7:0]  paddr = '0, profile_address;
	logic [31:0] pwdata = '0, prdata, primary_channel_word, rd;
	logic [3:0]  want_pins = '0, profile_pin;
	logic [2:0]  want_sdio = '0, serial_data_pin;
	pskey_kps_t  keying_parameter_select;
	int          mismatches = 0, num_checks = 0, cyc = 0;

	pskey_top pskey_top_i (.clock(clock), .nrst(nrst), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .profile_pin(profile_pin),
		.serial_data_pin(serial_data_pin),
		.primary_channel_word(primary_channel_word),
		.keying_parameter_select(keying_parameter_select),
		.profile_address(profile_address), .ramp_up(ramp_up),
		.ramp_down(ramp_down), .serial_single_bit(serial_single_bit));
	pskey_ctrl_model pskey_ctrl_model_i (.clock(clock),
		.want_pins(want_pins), .want_sdio(want_sdio),
		.profile_pin(profile_pin), .serial_data_pin(serial_data_pin));

	// ============================================================
	// Clock, hang guard and verdict
	initial
		forever #2 clock = ~clock;
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			mismatches++;
			wrap_up;
		end
	end
	task automatic wrap_up;
		if (mismatches == 0 && num_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// Profile contents; index zero differs per keyed parameter
	function automatic logic [31:0] pv(input logic [4:0] n,
		input logic [1:0] k);
		pv = (n == 0) ? {4'h0, k, 26'h1234567} : {n[3:0], 28'hC0FFEE1};
	endfunction

	// One APB transfer; holds the request until pready is seen
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		@(posedge clock);
		// Only the bench timeout ends a wait for the answer
		while (pready !== 1'b1)
			@(posedge clock);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge clock);
	endtask

	// Set a mode and pins, wait model edge plus four, compare all; profile address only when the mode is not refused
	task automatic run(input logic [1:0] k, lv, rm,
		input logic [2:0] pc, input logic [3:0] p,
		input logic [2:0] s, input logic [4:0] n, input logic u, dn);
		logic [31:0] v;
		logic [7:0]  a0;
		logic [15:0] st;
		apb(1'b1, PSKEY_OFF_CTRL, {23'h0, k, pc, rm, lv});
		want_pins <= p;
		want_sdio <= s;
		repeat (5) @(posedge clock);
		v = pv(n, k);
		a0 = (k == PSKEY_KEY_AMPL) ? PSKEY_REG_AMPL0 :
			(k == PSKEY_KEY_PHASE) ? PSKEY_REG_PHASE0 : PSKEY_REG_FREQ0;
		if (k == PSKEY_KEY_AMPL)
			v = v >> (32 - PSKEY_AMPL_W);
		else if (k == PSKEY_KEY_PHASE)
			v = v >> (32 - PSKEY_PHASE_W);
		if (n == 5'd16)
			v = '0;
		`CHK(primary_channel_word, v)
		if (n != 5'd16)
			`CHK(profile_address, (n == 0) ? a0 : PSKEY_REG_PBASE + 8'(n))
		`CHK({ramp_up, ramp_down}, {u, dn})
		`CHK(serial_single_bit, rm == 2'd3)
		`CHK(keying_parameter_select, k)
		// Word and status registers mirror the settled selection
		apb(1'b0, PSKEY_OFF_WORD, '0);
		`CHK(rd, v)
		st = {rm == 2'd3, n != 5'd16, dn, u, n[3:0], 1'b0, s, p};
		apb(1'b0, PSKEY_OFF_STATUS, '0);
		`CHK(rd, {16'h0, st})
	endtask

	// ============================================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clock);
		nrst <= 1'b1;
		repeat (5) @(posedge clock);
		apb(1'b0, PSKEY_OFF_CTRL, '0);
		`CHK(rd, PSKEY_CTRL_RST)
		apb(1'b0, 8'hF0, '0);
		`CHK({err, rd}, {1'b1, 32'h0})
		for (int n = 1; n < 16; n++)
			apb(1'b1, PSKEY_OFF_PROF1 + 8'(4 * n), pv(5'(n), 2'd2));
		apb(1'b1, PSKEY_OFF_PROF0, pv(5'd0, 2'd2));
		apb(1'b1, PSKEY_OFF_PROF0 + 8'h04, pv(5'd0, 2'd3));
		apb(1'b1, PSKEY_OFF_PROF0 + 8'h08, pv(5'd0, 2'd1));
		apb(1'b0, PSKEY_OFF_PROF1 + 8'h3C, '0);
		`CHK(rd, pv(5'd15, 2'd2))
		run(2, 0, 0, 7, 4'b0010, 3'b000, 1, 0, 0);
		run(1, 0, 0, 7, 4'b1101, 3'b000, 0, 0, 0);
		run(2, 1, 0, 3, 4'b0001, 3'b000, 2, 0, 0);
		run(1, 2, 0, 1, 4'b1011, 3'b000, 6, 0, 0);
		run(3, 3, 0, 5, 4'b0111, 3'b000, 14, 0, 0);
		run(2, 0, 1, 0, 4'b1010, 3'b000, 1, 0, 1);
		run(2, 0, 1, 3, 4'b0001, 3'b000, 1, 1, 0);
		run(2, 2, 2, 1, 4'b0101, 3'b000, 5, 1, 0);
		run(2, 0, 3, 7, 4'b0010, 3'b010, 1, 1, 0);
		run(2, 0, 3, 7, 4'b0000, 3'b110, 0, 0, 1);
		run(3, 1, 3, 0, 4'b0100, 3'b010, 2, 0, 1);
		run(2, 1, 3, 3, 4'b0010, 3'b000, 1, 1, 0);
		run(2, 3, 3, 1, 4'b1011, 3'b001, 13, 0, 1);
		run(2, 1, 1, 3, 4'b0011, 3'b000, 16, 0, 0);
		run(2, 0, 2, 1, 4'b0011, 3'b000, 16, 0, 0);
		run(2, 2, 3, 1, 4'b0011, 3'b000, 16, 0, 0);
		wrap_up;
	end
endmodule
